// ===== hw/snvm_defines.svh
// Offsets, field positions, reset values and timing counts for the NVM control
`ifndef SNVM_DEFINES_SVH
`define SNVM_DEFINES_SVH

// Register offsets on the serial control port
`define SNVM_OFF_BUSY     12'hB00
`define SNVM_OFF_ERROR    12'hB01
`define SNVM_OFF_RELOAD   12'hB02
`define SNVM_OFF_SAVE     12'hB03

// Field positions
`define SNVM_BIT_BUSY     0
`define SNVM_BIT_ERROR    0
`define SNVM_BIT_WREN     0
`define SNVM_BIT_RELOAD   1
`define SNVM_BIT_SAVE     0
`define SNVM_BIT_CMDTYPE  7

// Reset values
`define SNVM_RST_BYTE     8'h00

// Segment command list location and operational codes
`define SNVM_LIST_BASE    12'hA00
`define SNVM_OP_UPDATE    8'h80

// Least gap between transfers, kept by the host
`define SNVM_GAP_NS       10000
`define SNVM_CLK_NS       50
`define SNVM_GAP_CYCLES   ((`SNVM_GAP_NS + `SNVM_CLK_NS - 1) / `SNVM_CLK_NS)

`endif

// ===== hw/snvm_pkg.sv
// Types shared by the settings NVM transfer control
`default_nettype none
package snvm_pkg;

	// Register access from the serial control port
	typedef struct packed {
		logic        wr;
		logic        rd;
		logic [11:0] addr;
		logic [7:0]  data;
	} snvm_req_t;

	// Write side towards the buffer register bank
	typedef struct packed {
		logic        we;
		logic [11:0] addr;
		logic [7:0]  data;
	} snvm_bank_t;

	// Transfer engine states
	typedef enum logic [5:0] {
		ST_IDLE = 6'b000001,
		ST_CMD  = 6'b000010,
		ST_AHI  = 6'b000100,
		ST_ALO  = 6'b001000,
		ST_DATA = 6'b010000,
		ST_SUM  = 6'b100000
	} snvm_state_t;

endpackage
`default_nettype wire

// ===== hw/settings_nvm_transfer_control.sv
// Settings NVM transfer control: registers, transfer engine and store array
//
// Functional notes
// R1 - Busy register bit 0 reads 1 during any store transfer, else 0.
// R2 - Status pin shows the busy flag when the routing control is set.
// R3 - Error register bit 0 reads 1 after bad data, 0 after good data.
// R4 - With strap low, bit 1 starts soft reset and reload; self-clears.
// R5 - Write enable bit 0 resets to 0 and blocks every save while 0.
// R6 - Host waits at least 10 us between consecutive save or load transfers.
// R7 - Writing 1 to save bit 0 starts copying buffer bank into store.
// R8 - Save bit clears itself when the copy into the store finishes.
// R9 - Command top bit 0: length minus one, then two address bytes, MSB first.
// R10 - Busy also covers reload; error reflects the most recent transfer.
`default_nettype none
`include "snvm_defines.svh"

module settings_nvm_transfer_control #(
	parameter int STORE_DEPTH = 256
) (
	input  wire logic               clock,
	input  wire logic               rst,
	input  wire snvm_pkg::snvm_req_t regReq,
	output logic [7:0]              regRdData,
	input  wire logic               strapPin,
	input  wire logic               statusRouteBusy,
	input  wire logic               statusOther,
	output logic                    statusPin,
	output snvm_pkg::snvm_bank_t    bankWr,
	output logic [11:0]             bankRdAddr,
	input  wire logic [7:0]         bankRdData,
	output logic                    ioUpdate,
	output logic                    softReset
);
	import snvm_pkg::*;

	localparam int PW = $clog2(STORE_DEPTH);

	// ------------------------------------------------------------------
	// State
	// ------------------------------------------------------------------
	snvm_state_t   state,     next_state;
	logic          busy,      next_busy;
	logic          dataErr,   next_dataErr;
	logic          writeEn,   next_writeEn;
	logic          reloadReq, next_reloadReq;
	logic          saveReq,   next_saveReq;
	logic          modeSave,  next_modeSave;
	logic [7:0]    listIdx,   next_listIdx;
	logic [6:0]    count,     next_count;
	logic [15:0]   segAddr,   next_segAddr;
	logic [PW-1:0] storePtr,  next_storePtr;
	logic [7:0]    sum,       next_sum;
	logic [7:0]    rdData,    next_rdData;
	logic          upd,       next_upd;
	logic          srst,      next_srst;

	// Store array and its write port
	logic [7:0]    store [STORE_DEPTH];
	logic          storeWe;
	logic [7:0]    storeWrData;
	logic [7:0]    storeRdData;
	logic [7:0]    cmdByte;
	logic          startSave;
	logic          startLoad;

	assign storeRdData = store[storePtr];
	assign cmdByte     = bankRdData;

	// ------------------------------------------------------------------
	// Start decode
	// ------------------------------------------------------------------
	// Writes that would start a transfer are ignored while one is running
	always_comb begin
		startSave = 1'b0;
		startLoad = 1'b0;
		if (regReq.wr && !busy) begin
			if (regReq.addr == `SNVM_OFF_SAVE) begin
				startSave = regReq.data[`SNVM_BIT_SAVE] & writeEn; // [R5] [R7]
			end else if (regReq.addr == `SNVM_OFF_RELOAD) begin
				startLoad = regReq.data[`SNVM_BIT_RELOAD] & ~strapPin; // [R4]
			end
		end
	end

	// ------------------------------------------------------------------
	// Next-state logic for registers and engine
	// ------------------------------------------------------------------
	always_comb begin
		next_state     = state;
		next_busy      = busy;
		next_dataErr   = dataErr;
		next_writeEn   = writeEn;
		next_reloadReq = reloadReq;
		next_saveReq   = saveReq;
		next_modeSave  = modeSave;
		next_listIdx   = listIdx;
		next_count     = count;
		next_segAddr   = segAddr;
		next_storePtr  = storePtr;
		next_sum       = sum;
		next_rdData    = rdData;
		next_upd       = 1'b0;
		next_srst      = 1'b0;
		storeWe        = 1'b0;
		storeWrData    = storeRdData;
		bankWr         = '0;
		bankRdAddr     = `SNVM_LIST_BASE + {4'h0, listIdx};

		// Protection bit is plain read/write, never touched by the engine
		if (regReq.wr && regReq.addr == `SNVM_OFF_RELOAD) begin
			next_writeEn = regReq.data[`SNVM_BIT_WREN]; // [R5]
		end

		// Register read, registered for a clean one-cycle answer
		if (regReq.rd) begin
			if (regReq.addr == `SNVM_OFF_BUSY) begin
				next_rdData = {7'h00, busy}; // [R1]
			end else if (regReq.addr == `SNVM_OFF_ERROR) begin
				next_rdData = {7'h00, dataErr}; // [R3]
			end else if (regReq.addr == `SNVM_OFF_RELOAD) begin
				next_rdData = {6'h00, reloadReq, writeEn};
			end else if (regReq.addr == `SNVM_OFF_SAVE) begin
				next_rdData = {7'h00, saveReq};
			end else begin
				next_rdData = `SNVM_RST_BYTE;
			end
		end

		case (state)
			ST_IDLE: begin
				if (startSave || startLoad) begin
					next_state     = ST_CMD;
					next_busy      = 1'b1; // [R1] [R10]
					next_modeSave  = startSave;
					next_saveReq   = startSave; // [R7]
					next_reloadReq = startLoad; // [R4]
					next_srst      = startLoad; // [R4]
					next_listIdx   = 8'h00;
					next_storePtr  = '0;
					next_sum       = 8'h00;
				end
			end
			ST_CMD: begin
				// Top bit selects data transfer or operational code
				if (!cmdByte[`SNVM_BIT_CMDTYPE]) begin
					next_count   = cmdByte[6:0]; // [R9]
					next_listIdx = listIdx + 8'h01;
					next_state   = ST_AHI;
				end else if (cmdByte == `SNVM_OP_UPDATE) begin
					next_upd     = 1'b1;
					next_listIdx = listIdx + 8'h01;
				end else begin
					next_state = ST_SUM; // End of data
				end
			end
			ST_AHI: begin
				next_segAddr[15:8] = cmdByte; // [R9]
				next_listIdx       = listIdx + 8'h01;
				next_state         = ST_ALO;
			end
			ST_ALO: begin
				next_segAddr[7:0] = cmdByte; // [R9]
				next_listIdx      = listIdx + 8'h01;
				next_state        = ST_DATA;
			end
			ST_DATA: begin
				bankRdAddr = segAddr[11:0];
				if (modeSave) begin
					storeWe     = 1'b1;
					storeWrData = bankRdData;
					next_sum    = sum + bankRdData;
				end else begin
					bankWr.we   = 1'b1;
					bankWr.addr = segAddr[11:0];
					bankWr.data = storeRdData;
					next_sum    = sum + storeRdData;
				end
				next_storePtr = storePtr + PW'(1);
				next_segAddr  = segAddr + 16'h0001;
				if (count == 7'h00) begin
					next_state = ST_CMD;
				end else begin
					next_count = count - 7'h01;
				end
			end
			ST_SUM: begin
				// Save appends a checksum; load compares against it
				if (modeSave) begin
					storeWe      = 1'b1;
					storeWrData  = sum;
					next_dataErr = 1'b0; // [R10]
				end else begin
					next_dataErr = (storeRdData != sum); // [R3] [R10]
				end
				next_busy      = 1'b0; // [R1]
				next_saveReq   = 1'b0; // [R8]
				next_reloadReq = 1'b0; // [R4]
				next_state     = ST_IDLE;
			end
			default: begin
				next_state = ST_IDLE;
			end
		endcase
	end

	// ------------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------------
	always_ff @(posedge clock) begin
		if (rst) begin
			state     <= ST_IDLE;
			busy      <= 1'b0;
			dataErr   <= 1'b0;
			writeEn   <= 1'b0; // [R5]
			reloadReq <= 1'b0;
			saveReq   <= 1'b0;
			modeSave  <= 1'b0;
			listIdx   <= 8'h00;
			count     <= 7'h00;
			segAddr   <= 16'h0000;
			storePtr  <= '0;
			sum       <= 8'h00;
			rdData    <= `SNVM_RST_BYTE;
			upd       <= 1'b0;
			srst      <= 1'b0;
		end else begin
			state     <= next_state;
			busy      <= next_busy;
			dataErr   <= next_dataErr;
			writeEn   <= next_writeEn;
			reloadReq <= next_reloadReq;
			saveReq   <= next_saveReq;
			modeSave  <= next_modeSave;
			listIdx   <= next_listIdx;
			count     <= next_count;
			segAddr   <= next_segAddr;
			storePtr  <= next_storePtr;
			sum       <= next_sum;
			rdData    <= next_rdData;
			upd       <= next_upd;
			srst      <= next_srst;
		end
	end

	// Store contents survive reset, as a nonvolatile array should
	always_ff @(posedge clock) begin
		if (storeWe) begin
			store[storePtr] <= storeWrData;
		end
	end

	// ------------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------------
	assign regRdData = rdData;
	assign ioUpdate  = upd;
	assign softReset = srst;
	assign statusPin = statusRouteBusy ? busy : statusOther; // [R2]

endmodule
`default_nettype wire

// ===== verif/snvm_bank_model.sv
// Buffer register bank model holding a preset segment command list
`default_nettype none
module snvm_bank_model
	import snvm_pkg::*;
(
	input  wire logic        clock,
	input  wire snvm_bank_t  bankWr,
	input  wire logic [11:0] bankRdAddr,
	output logic [7:0]       bankRdData
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] mem [0:4095];
	// ----------------------------------------------------------
	// List: two bytes from 0x010 MSB first, update, end of data
	// ----------------------------------------------------------
	initial begin
		foreach (mem[i]) mem[i] = 8'h00;
		mem[12'hA00] = 8'h01;
		mem[12'hA02] = 8'h10;
		mem[12'hA03] = 8'h80;
		mem[12'hA04] = 8'hFF;
		mem[12'h010] = 8'h5A;
		mem[12'h011] = 8'hC3;
	end
	// Read is combinational, the engine samples it in the same cycle
	assign bankRdData = mem[bankRdAddr];
	always @(posedge clock) begin
		if (bankWr.we) mem[bankWr.addr] <= bankWr.data;
	end
endmodule
`default_nettype wire

// ===== verif/snvm_asserts.sv
// Port checker for the settings NVM transfer control
`default_nettype none
`include "snvm_defines.svh"
module snvm_chk
	import snvm_pkg::*;
(
	input  wire logic        clock,
	input  wire logic        rst,
	input  wire snvm_req_t   regReq,
	input  wire logic [7:0]  regRdData,
	input  wire logic        strapPin,
	input  wire logic        statusRouteBusy,
	input  wire logic        statusOther,
	input  wire logic        statusPin,
	input  wire snvm_bank_t  bankWr,
	input  wire logic        ioUpdate,
	input  wire logic        softReset
);
	timeunit 1ns;
	timeprecision 1ns;
	// ----------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------
	default clocking cb @(posedge clock); endclocking
	default disable iff (rst);
	sequence s_reload_req;
		regReq.wr && regReq.addr == `SNVM_OFF_RELOAD && regReq.data[1];
	endsequence
	a_status_other: assert property (!statusRouteBusy |->
		statusPin == statusOther) else $error("status pin wrong");
	a_ro_upper: assert property (regReq.rd && regReq.addr <= 12'hB01 &&
		regReq.addr >= 12'hB00 |=> regRdData[7:1] == 7'h00)
		else $error("unused bits set");
	a_unmapped_zero: assert property (regReq.rd && !(regReq.addr inside
		{[12'hB00:12'hB03]}) |=> regRdData == 8'h00)
		else $error("unmapped read not zero");
	a_read_holds: assert property (!regReq.rd |=> $stable(regRdData))
		else $error("read data moved");
	a_reload_strap: assert property (s_reload_req ##0 strapPin |=>
		!softReset) else $error("reload with strap high");
	a_reset_single: assert property (softReset |=> !softReset)
		else $error("soft reset too long");
	a_load_writes: assert property (softReset |-> ##[1:30] bankWr.we)
		else $error("reload wrote no bank");
	a_update_single: assert property (ioUpdate |=> !ioUpdate)
		else $error("update pulse too long");
endmodule
`default_nettype wire

// ===== verif/tb.sv
// Self-checking bench for the settings NVM transfer control
`default_nettype none
`include "snvm_defines.svh"
module tb;
	import snvm_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;
	logic        clock, rst, strapPin, statusRouteBusy, statusOther;
	logic        statusPin, ioUpdate, softReset;
	logic [7:0]  regRdData, bankRdData, d;
	logic [11:0] bankRdAddr;
	snvm_req_t   regReq;
	snvm_bank_t  bankWr;
	int          fail_count = 0;
	int          checks_done = 0;
	int          updCount = 0;
	int          srstCount = 0;
	settings_nvm_transfer_control uut (.clock(clock), .rst(rst),
		.regReq(regReq), .regRdData(regRdData), .strapPin(strapPin),
		.statusRouteBusy(statusRouteBusy), .statusOther(statusOther),
		.statusPin(statusPin), .bankWr(bankWr), .bankRdAddr(bankRdAddr),
		.bankRdData(bankRdData), .ioUpdate(ioUpdate),
		.softReset(softReset));
	snvm_bank_model bank (.clock(clock), .bankWr(bankWr),
		.bankRdAddr(bankRdAddr), .bankRdData(bankRdData));
	// Pulse counters, sampled mid-cycle where the outputs have settled
	always @(negedge clock) begin
		if (ioUpdate) updCount++;
		if (softReset) srstCount++;
	end
	// ----------------------------------------------------------
	// Bus tasks, all entered and left 5 ns after a rising edge
	// ----------------------------------------------------------
	// An idle edge follows each strobe so calls may run back to back
	task automatic wr(input logic [11:0] a, input logic [7:0] v);
		regReq = '{wr: 1'b1, rd: 1'b0, addr: a, data: v};
		@(posedge clock); #5;
		regReq.wr = 1'b0;
		@(posedge clock); #5;
	endtask
	// Plain read; the answer is registered at the strobe's edge
	task automatic rd(input logic [11:0] a);
		regReq = '{wr: 1'b0, rd: 1'b1, addr: a, data: 8'h00};
		@(posedge clock); #5;
		regReq.rd = 1'b0;
		d = regRdData;
		@(posedge clock); #5;
	endtask
	task automatic chk(input string n, input logic [7:0] e, g);
		checks_done++;
		if (g !== e) begin
			fail_count++;
			$display("[FAIL] %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic rc(input logic [11:0] a, input logic [7:0] e);
		rd(a);
		chk($sformatf("reg %h", a), e, d);
	endtask
	// Polls busy without counting; a hang counts one mismatch
	task automatic wait_idle();
		for (int i = 0; i < 400; i++) begin
			rd(`SNVM_OFF_BUSY);
			if (d === 8'h00) begin
				return;
			end
		end
		fail_count++;
		$display("[FAIL] busy expected 00 seen %h", d);
		results();
	endtask
	// Host side of the least gap between transfers
	task automatic gap();
		repeat (`SNVM_GAP_CYCLES) @(posedge clock);
		#5;
	endtask
	// Reset values, an unmapped place, status pin with routing off
	task automatic t_reset();
		rc(`SNVM_OFF_BUSY, 8'h00);
		rc(`SNVM_OFF_ERROR, 8'h00);
		rc(`SNVM_OFF_RELOAD, 8'h00);
		rc(`SNVM_OFF_SAVE, 8'h00);
		rc(12'h400, 8'h00);
		chk("statusPin", 8'h01, {7'h00, statusPin});
		statusOther = 1'b0;
		@(posedge clock); #5;
		chk("statusPin", 8'h00, {7'h00, statusPin});
		statusOther = 1'b1;
		$display("t_reset done");
	endtask
	// Save while protected must not start
	task automatic t_locked();
		wr(`SNVM_OFF_SAVE, 8'h01);
		rc(`SNVM_OFF_BUSY, 8'h00);
		rc(`SNVM_OFF_SAVE, 8'h00);
		$display("t_locked done");
	endtask
	// Unprotected save, busy on the pin, self-clear
	task automatic t_save();
		wr(`SNVM_OFF_RELOAD, 8'h01);
		rc(`SNVM_OFF_RELOAD, 8'h01);
		statusRouteBusy = 1'b1;
		wr(`SNVM_OFF_SAVE, 8'h01);
		chk("statusPin", 8'h01, {7'h00, statusPin});
		rc(`SNVM_OFF_SAVE, 8'h01);
		rc(`SNVM_OFF_BUSY, 8'h01);
		wait_idle();
		chk("statusPin", 8'h00, {7'h00, statusPin});
		rc(`SNVM_OFF_SAVE, 8'h00);
		rc(`SNVM_OFF_ERROR, 8'h00);
		chk("ioUpdate pulses", 8'h01, updCount[7:0]);
		$display("t_save done");
	endtask
	// Refused reload with strap high, then a real reload
	task automatic t_reload();
		gap();
		wr(`SNVM_OFF_RELOAD, 8'h03);
		rc(`SNVM_OFF_BUSY, 8'h00);
		rc(`SNVM_OFF_RELOAD, 8'h01);
		chk("softReset pulses", 8'h00, srstCount[7:0]);
		bank.mem[12'h010] = 8'h00;
		bank.mem[12'h011] = 8'h00;
		strapPin = 1'b0;
		wr(`SNVM_OFF_RELOAD, 8'h03);
		rc(`SNVM_OFF_RELOAD, 8'h03);
		rc(`SNVM_OFF_BUSY, 8'h01);
		wait_idle();
		rc(`SNVM_OFF_RELOAD, 8'h01);
		rc(`SNVM_OFF_ERROR, 8'h00);
		chk("bank 010", 8'h5A, bank.mem[12'h010]);
		chk("bank 011", 8'hC3, bank.mem[12'h011]);
		chk("softReset pulses", 8'h01, srstCount[7:0]);
		chk("ioUpdate pulses", 8'h02, updCount[7:0]);
		$display("t_reload done");
	endtask
	// Shortened list: the load meets a data byte where the sum should be
	task automatic t_error();
		gap();
		bank.mem[12'hA00] = 8'h00;
		wr(`SNVM_OFF_RELOAD, 8'h03);
		wait_idle();
		rc(`SNVM_OFF_ERROR, 8'h01);
		chk("bank 010", 8'h5A, bank.mem[12'h010]);
		bank.mem[12'hA00] = 8'h01;
		gap();
		wr(`SNVM_OFF_SAVE, 8'h01);
		wait_idle();
		rc(`SNVM_OFF_ERROR, 8'h00);
		rc(`SNVM_OFF_SAVE, 8'h00);
		$display("t_error done");
	endtask
	task automatic results();
		$display("checks %0d mismatches %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	initial begin
		clock = 1'b0;
		forever #25 clock = ~clock;
	end
	initial begin
		regReq = '0;
		strapPin = 1'b1;
		statusRouteBusy = 1'b0;
		statusOther = 1'b1;
		rst = 1'b1;
		repeat (5) @(posedge clock);
		#5;
		rst = 1'b0;
		t_reset();
		t_locked();
		t_save();
		t_reload();
		t_error();
		results();
	end
endmodule
bind settings_nvm_transfer_control snvm_chk chk (.clock(clock),
	.rst(rst), .regReq(regReq), .regRdData(regRdData),
	.strapPin(strapPin), .statusRouteBusy(statusRouteBusy),
	.statusOther(statusOther), .statusPin(statusPin), .bankWr(bankWr),
	.ioUpdate(ioUpdate), .softReset(softReset));
`default_nettype wire
